// [pio_ports.sv]
// Purpose: Three parallel I/O ports with write-only direction registers
// Assumes: Core presents file address, read/write strobes and the working register
// Notes:   Read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ps
`include "pio_regs.svh"
module pio_ports #(
  parameter bit HAS_THIRD = 1'b1
) (
  // Clock, enable, resets
  input  wire logic                    i_clock,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_clk_en,
  input  wire logic                    i_por,
  // Core file access
  input  wire logic [`PIO_ADDR_W-1:0]  i_addr,
  input  wire logic                    i_rd,
  input  wire logic                    i_wr,
  input  wire logic [7:0]              i_wdata,
  output logic      [7:0]              o_rdata,
  // Direction-load instruction
  input  wire logic                    i_dir_load,
  input  wire logic [7:0]              i_work,
  // First port pins
  input  wire logic [`PIO_FIRST_W-1:0] i_first_port_pins,
  output logic      [`PIO_FIRST_W-1:0] o_first_port_pins,
  output logic      [`PIO_FIRST_W-1:0] o_first_port_oe_n,
  // Second port pins
  input  wire logic [7:0]              i_second_port_pins,
  output logic      [7:0]              o_second_port_pins,
  output logic      [7:0]              o_second_port_oe_n,
  // Third port pins
  input  wire logic [7:0]              i_third_port_pins,
  output logic      [7:0]              o_third_port_pins,
  output logic      [7:0]              o_third_port_oe_n
);
  import pio_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic pio_sel_t pio_decode(input logic [`PIO_ADDR_W-1:0] a);
    case (a)
      `PIO_FIRST_ADDR:  pio_decode = PIO_SEL_FIRST;
      `PIO_SECOND_ADDR: pio_decode = PIO_SEL_SECOND;
      `PIO_THIRD_ADDR:  pio_decode = PIO_SEL_THIRD;
      default:          pio_decode = PIO_SEL_NONE;
    endcase
  endfunction : pio_decode

  pio_sel_t wsel, rsel;
  assign wsel = pio_decode(i_addr);
  assign rsel = pio_decode(i_addr);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // All twenty pins share one synchroniser; the level reaches the read
  // path some four cycles after the pin moves, so slow edges are safe
  logic [`PIO_PIN_COUNT-1:0] pins_raw;
  logic [`PIO_PIN_COUNT-1:0] pins_lvl;
  assign pins_raw = {i_third_port_pins, i_second_port_pins, i_first_port_pins};

  pio_pin_sync #(.WIDTH(`PIO_PIN_COUNT)) u_sync (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_pins    (pins_raw),
    .o_level   (pins_lvl)
  );

  // ----------------------------------------------------------------
  // Latches, direction registers, read data
  // ----------------------------------------------------------------
  logic [`PIO_FIRST_W-1:0] first_lat_reg, first_lat_next;
  logic [7:0]              second_lat_reg, second_lat_next;
  logic [7:0]              third_lat_reg, third_lat_next;
  logic [`PIO_FIRST_W-1:0] first_dir_reg, first_dir_next;
  logic [7:0]              second_dir_reg, second_dir_next;
  logic [7:0]              third_dir_reg, third_dir_next;
  logic [7:0]              rdata_reg, rdata_next;

  always_comb begin
    first_lat_next  = first_lat_reg;
    second_lat_next = second_lat_reg;
    third_lat_next  = third_lat_reg;
    first_dir_next  = first_dir_reg;
    second_dir_next = second_dir_reg;
    third_dir_next  = third_dir_reg;
    rdata_next      = rdata_reg;
    if (i_wr) begin
      case (wsel)
        PIO_SEL_FIRST:  first_lat_next  = i_wdata[`PIO_FIRST_W-1:0];
        PIO_SEL_SECOND: second_lat_next = i_wdata;
        PIO_SEL_THIRD:  third_lat_next  = i_wdata;
        default: ;
      endcase
    end
    // Only the direction-load instruction reaches direction bits
    if (i_dir_load) begin
      case (wsel)
        PIO_SEL_FIRST:  first_dir_next  = i_work[`PIO_FIRST_W-1:0];
        PIO_SEL_SECOND: second_dir_next = i_work;
        PIO_SEL_THIRD:  third_dir_next  = i_work;
        default: ;
      endcase
    end
    if (i_rd) begin
      case (rsel)
        PIO_SEL_FIRST:  rdata_next = {4'h0, pins_lvl[3:0]};
        PIO_SEL_SECOND: rdata_next = pins_lvl[11:4];
        PIO_SEL_THIRD:  rdata_next = HAS_THIRD ? pins_lvl[19:12]
                                               : third_lat_reg;
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      first_dir_reg  <= `PIO_FIRST_W'(`PIO_DIR_RESET);
      second_dir_reg <= `PIO_DIR_RESET;
      third_dir_reg  <= `PIO_DIR_RESET;
      rdata_reg      <= 8'h00;
      // Latches are kept over master clear and watchdog resets
      if (i_por) begin
        first_lat_reg  <= `PIO_FIRST_W'(`PIO_LATCH_PORRST);
        second_lat_reg <= `PIO_LATCH_PORRST;
        third_lat_reg  <= `PIO_LATCH_PORRST;
      end
    end else if (i_clk_en) begin
      first_lat_reg  <= first_lat_next;
      second_lat_reg <= second_lat_next;
      third_lat_reg  <= third_lat_next;
      first_dir_reg  <= first_dir_next;
      second_dir_reg <= second_dir_next;
      third_dir_reg  <= third_dir_next;
      rdata_reg      <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign o_rdata            = rdata_reg;
  assign o_first_port_pins  = first_lat_reg;
  assign o_first_port_oe_n  = first_dir_reg;
  assign o_second_port_pins = second_lat_reg;
  assign o_second_port_oe_n = second_dir_reg;
  assign o_third_port_pins  = HAS_THIRD ? third_lat_reg : 8'h00;
  assign o_third_port_oe_n  = HAS_THIRD ? third_dir_reg : 8'hff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_dir_reset: assert property (@(posedge i_clock) i_sys_rst |=>
    (o_first_port_oe_n == 4'hf) && (o_second_port_oe_n == 8'hff) && (o_third_port_oe_n == 8'hff))
    else $error("direction not set by reset");
  chk_rdata_reset: assert property (@(posedge i_clock) i_sys_rst |=>
    o_rdata == 8'h00)
    else $error("read data not cleared by reset");
  chk_first_read: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clk_en && i_rd && i_addr == `PIO_FIRST_ADDR |=> o_rdata[3:0] == $past(pins_lvl[3:0]))
    else $error("first port read not pin level");
  chk_third_read: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clk_en && i_rd && i_addr == `PIO_THIRD_ADDR |=>
    o_rdata == (HAS_THIRD ? $past(pins_lvl[19:12]) : $past(third_lat_reg)))
    else $error("third location read wrong");
  chk_unmapped_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clk_en && i_rd && (i_addr < `PIO_FIRST_ADDR || i_addr > `PIO_THIRD_ADDR) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_enable_freeze: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !i_clk_en |=> $stable(o_rdata) && $stable(o_first_port_pins) && $stable(o_second_port_oe_n))
    else $error("state moved with enable low");
  chk_first_latch: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clk_en && i_wr && i_addr == `PIO_FIRST_ADDR |=> o_first_port_pins == $past(i_wdata[3:0]))
    else $error("first latch not written");
  chk_por_clear: assert property (@(posedge i_clock)
    i_sys_rst && i_por |=> (o_first_port_pins == 4'h0) && (o_second_port_pins == 8'h00))
    else $error("latch not cleared by power-on reset");
  chk_first_upper: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clk_en && i_rd && i_addr == `PIO_FIRST_ADDR |=> o_rdata[7:4] == 4'h0)
    else $error("first port upper bits not zero");
  chk_read_pins: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clk_en && i_rd && i_addr == `PIO_SECOND_ADDR |=> o_rdata == $past(pins_lvl[11:4]))
    else $error("second port read not pin level");
  chk_latch_write: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clk_en && i_wr && i_addr == `PIO_SECOND_ADDR |=> o_second_port_pins == $past(i_wdata))
    else $error("latch not written");
  chk_latch_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !(i_wr && i_addr == `PIO_SECOND_ADDR) |=> $stable(o_second_port_pins))
    else $error("latch changed without write");
  chk_dir_only_load: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !i_dir_load |=> $stable(o_second_port_oe_n))
    else $error("direction changed without load");
  chk_dir_load: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clk_en && i_dir_load && i_addr == `PIO_FIRST_ADDR |=> o_first_port_oe_n == $past(i_work[3:0]))
    else $error("direction load wrong");
  chk_latch_keep: assert property (@(posedge i_clock)
    i_sys_rst && !i_por |=> $stable(o_second_port_pins))
    else $error("latch lost over warm reset");
endmodule : pio_ports

// [pio_regs.svh]
// Purpose: Register offsets, reset values and field sizes of the parallel ports
// Assumes: Data-memory file addresses are 5 bits wide
// Notes:   Definitions only
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

`define PIO_ADDR_W        5
`define PIO_FIRST_ADDR    5'h05
`define PIO_SECOND_ADDR   5'h06
`define PIO_THIRD_ADDR    5'h07
`define PIO_FIRST_W       4
`define PIO_DIR_RESET     8'hff
`define PIO_LATCH_PORRST  8'h00
`define PIO_SYNC_STAGES   3
`define PIO_PIN_COUNT     20

`endif

// [pio_pkg.sv]
// Purpose: Types shared by the parallel port files
// Assumes: Nothing
// Notes:   Constants live in pio_regs.svh
package pio_pkg;
  typedef enum logic [1:0] {
    PIO_SEL_FIRST,
    PIO_SEL_SECOND,
    PIO_SEL_THIRD,
    PIO_SEL_NONE
  } pio_sel_t;
endpackage : pio_pkg

// [pio_pin_sync.sv]
// Purpose: Pin input synchroniser, three flops, change taken when stages 2 and 3 agree
// Assumes: One clock, clock enable freezes state
// Notes:   Stage one is read only by stage two
`timescale 1ns/1ps
module pio_pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clk_en,
  // Pins
  input  wire logic [WIDTH-1:0] i_pins,
  output logic      [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [WIDTH-1:0] s1_next, s2_next, s3_next, lvl_next;

  // Refuse a synchroniser with no bits at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("pio_pin_sync: WIDTH must be at least 1");
  end

  always_comb begin
    s1_next  = i_pins;
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    lvl_next = lvl_reg;
    for (int k = 0; k < WIDTH; k++) begin
      if (s2_reg[k] == s3_reg[k]) begin
        lvl_next[k] = s3_reg[k];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end else if (i_clk_en) begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sync_agree: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_clk_en && (s2_reg == s3_reg) |=> o_level == $past(s3_reg))
    else $error("synchronised level not taken on agreement");
endmodule : pio_pin_sync

// [pio_pin_model.sv]
// Purpose: Outside circuitry on the port pins
// Assumes: Bench supplies the level driven from outside
// Notes:   An enabled driver wins over the outside level
`timescale 1ns/1ps
module pio_pin_model #(
  parameter int W = 20
) (
  // Device side
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe_n,
  // Outside side
  input  wire logic [W-1:0] i_ext,
  output logic      [W-1:0] o_level
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  assign o_level = (i_oe_n & i_ext) | (~i_oe_n & i_out);
endmodule : pio_pin_model

// [parallel_io_ports_tb.sv]
// Purpose: Self-checking bench for pio_ports
// Assumes: u_dut at default HAS_THIRD with all three ports; u_dut_gpr built without the third
// Notes:   Integer model of latches and directions
`timescale 1ns/1ps
module parallel_io_ports_tb;
  import pio_pkg::*;
  logic        i_clock = 0, i_sys_rst = 1, i_clk_en = 1, i_por = 1;
  logic        i_rd = 0, i_wr = 0, i_dir_load = 0;
  logic [4:0]  i_addr = 5'h00;
  logic [7:0]  i_wdata = 8'h00, i_work = 8'h00, o_rdata, v;
  logic [19:0] ext = 20'h00000, lvl, o_out, o_oe_n;
  logic [7:0]  rd_gpr;
  logic [19:0] out_gpr, oe_gpr;
  int          error_cnt = 0, tests_run = 0, a, s;
  int          lat[3] = '{0, 0, 0}, dir[3] = '{255, 255, 255};
  pio_ports u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_por(i_por),
    .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_dir_load(i_dir_load), .i_work(i_work),
    .i_first_port_pins(lvl[3:0]), .o_first_port_pins(o_out[3:0]), .o_first_port_oe_n(o_oe_n[3:0]),
    .i_second_port_pins(lvl[11:4]), .o_second_port_pins(o_out[11:4]), .o_second_port_oe_n(o_oe_n[11:4]),
    .i_third_port_pins(lvl[19:12]), .o_third_port_pins(o_out[19:12]), .o_third_port_oe_n(o_oe_n[19:12]));
  pio_pin_model #(.W(20)) u_pins (.i_out(o_out), .i_oe_n(o_oe_n), .i_ext(ext), .o_level(lvl));
  // Variant without a third port: same traffic, address 07 is plain storage
  pio_ports #(.HAS_THIRD(1'b0)) u_dut_gpr (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_por(i_por), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(rd_gpr),
    .i_dir_load(i_dir_load), .i_work(i_work),
    .i_first_port_pins(lvl[3:0]), .o_first_port_pins(out_gpr[3:0]), .o_first_port_oe_n(oe_gpr[3:0]),
    .i_second_port_pins(lvl[11:4]), .o_second_port_pins(out_gpr[11:4]), .o_second_port_oe_n(oe_gpr[11:4]),
    .i_third_port_pins(lvl[19:12]), .o_third_port_pins(out_gpr[19:12]), .o_third_port_oe_n(oe_gpr[19:12]));
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  // ----------------------------------------
  // Model and helpers
  // ----------------------------------------
  function automatic logic [19:0] pack(input int m[3]);
    return {m[2][7:0], m[1][7:0], m[0][3:0]};
  endfunction : pack
  function automatic logic [7:0] exp_rd(input int k);
    logic [19:0] p;
    p = (pack(dir) & ext) | (~pack(dir) & pack(lat));
    return (k == 0) ? {4'h0, p[3:0]} : (k == 1) ? p[11:4] : p[19:12];
  endfunction : exp_rd
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic op(input logic [4:0] ad, input logic rd, input logic wr, input logic dl, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= ad; i_rd <= rd; i_wr <= wr; i_dir_load <= dl; i_wdata <= d; i_work <= d;
    @(posedge i_clock);
    i_rd <= 1'b0; i_wr <= 1'b0; i_dir_load <= 1'b0;
    #1;
  endtask : op
  task automatic rdchk(input int k);
    repeat (6) @(posedge i_clock);
    op(5'h05 + k[4:0], 1'b1, 1'b0, 1'b0, 8'h00);
    check({12'h000, o_rdata}, {12'h000, exp_rd(k)});
    if (k == 2) begin
      check({12'h000, rd_gpr}, {12'h000, lat[2][7:0]});
      check(out_gpr, pack(lat) & 20'h00fff);
      check(oe_gpr, pack(dir) | 20'hff000);
    end
  endtask : rdchk
  task automatic do_reset(input logic por);
    @(posedge i_clock);
    i_por <= por; i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    dir = '{255, 255, 255};
    if (por) lat = '{0, 0, 0};
    check(o_oe_n, 20'hfffff);
    check(o_out, pack(lat));
  endtask : do_reset
  task automatic end_sim;
    $display("error_cnt=%0d tests_run=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(57));
    do_reset(1'b1);
    $display("Test reset done");
    for (a = 0; a < 3; a++) begin
      v = 8'($urandom);
      op(5'h05 + a[4:0], 1'b0, 1'b1, 1'b0, v);
      lat[a] = v;
    end
    check(o_out, pack(lat));
    check(o_oe_n, 20'hfffff);
    ext = 20'($urandom);
    for (a = 0; a < 3; a++) rdchk(a);
    $display("Test latch while input done");
    repeat (40) begin
      a = $urandom_range(2);
      s = $urandom_range(2);
      v = 8'($urandom);
      op(5'h05 + a[4:0], 1'b0, s != 0, s != 1, v);
      if (s != 0) lat[a] = v;
      if (s != 1) dir[a] = v;
      ext = 20'($urandom);
      check(o_oe_n, pack(dir));
      check(o_out, pack(lat));
      rdchk(a);
    end
    $display("Test random traffic done");
    op(5'h1f, 1'b1, 1'b0, 1'b0, 8'h00);
    check({12'h000, o_rdata}, 20'h00000);
    op(5'h04, 1'b0, 1'b1, 1'b1, 8'h5a);
    check(o_out, pack(lat));
    check(o_oe_n, pack(dir));
    i_clk_en <= 1'b0;
    op(5'h06, 1'b0, 1'b1, 1'b1, ~v);
    i_clk_en <= 1'b1;
    check(o_out, pack(lat));
    check(o_oe_n, pack(dir));
    $display("Test unmapped and enable done");
    do_reset(1'b0);
    do_reset(1'b1);
    $display("Test warm and cold reset done");
    end_sim();
  end
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule : parallel_io_ports_tb
